// File: hw/touch_osc_cfg.svh
// Register map, field positions and constants of the touch oscillator control block
`ifndef TOUCH_OSC_CFG_SVH
`define TOUCH_OSC_CFG_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CAP_LOW 4'h0
`define OFS_CAP_HIGH 4'h4
`define OFS_OSC_CFG 4'h8
`define OFS_EN_CFG 4'hC

// ************************************************************
// Field positions
// ************************************************************
`define OSC_DBL_BIT 5
`define OSC_FIL_BIT 4
`define OSC_HOPC_BIT 3
`define EN_TSS_BIT 7
`define EN_ROEN_BIT 5
`define EN_KOEN_BIT 4

// ************************************************************
// Reset values and constants
// ************************************************************
`define CAP_RST 10'h000
`define OSC_RST 6'h00
`define KEYS_RST 4'h0
`define CAP_FULL_FF 32'h0000C350
`define CAP_SHIFT 10
`define KEYS_PER_MOD 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DIV4_LAST 2'h3

`endif

// File: hw/touch_osc_pkg.sv
// Types shared by the touch oscillator control block
package touch_osc_pkg;
  typedef logic [9:0] cap_code_t;
  typedef enum logic {
    SCAN_AUTO = 1'b0,
    SCAN_MANUAL = 1'b1
  } scan_mode_e;
  typedef enum logic [2:0] {
    SEL_CAP_LOW = 3'b000,
    SEL_CAP_HIGH = 3'b001,
    SEL_OSC_CFG = 3'b010,
    SEL_EN_CFG = 3'b011,
    SEL_NONE = 3'b100
  } reg_sel_e;
endpackage

// File: hw/touch_module_osc_control.sv
// Per-module touch oscillator control with AXI4-Lite register access
// Operation
// RQ1: Ten-bit capacitor code over two byte registers
// RQ2: Auto mode reloads code at slot end
// RQ3: Capacitance equals code times 50pF over 1024
// RQ4: Unimplemented config bits read as zero
// RQ5: Doubling enable doubles key oscillator frequency
// RQ6: Filter enable bit switches module filter
// RQ7: Hop control select picks field or hardware
// RQ8: Hop field selects 1.020 to 1.125 MHz
// RQ9: Hop field applies only with hardware off
// RQ10: Slot clock from reference oscillator or fsys/4
// RQ11: Manual mode software enables reference oscillator first
// RQ12: Busy falling edge clears reference oscillator enable
// RQ13: Auto mode start rise sets module 0 enable
// RQ14: Other modules set only under key/slot conditions
// RQ15: Manual mode software enables key oscillator first
// RQ16: Auto mode sets key oscillator, busy fall clears
// RQ17: Four key input enables per module
// RQ18: Global key number is 4n plus k
// RQ19: Mode select zero auto, one manual
// RQ20: Start rising edge starts detection
// RQ21: Busy set at start, cleared at scan end
// RQ22: Shared counter select uses module 0 counter
// RQ23: Edges detected on system clock, same-cycle update
`include "touch_osc_cfg.svh"

module touch_module_osc_control #(
  parameter int MODULE_IDX = 0,
  parameter int NUM_MODULES = 6,
  parameter int AW = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scan_start,
  input wire logic scan_busy,
  input wire touch_osc_pkg::scan_mode_e scan_mode_select,
  input wire logic shared_slot_counter_sel,
  input wire logic slot_end,
  input wire touch_osc_pkg::cap_code_t mem_cap_code,
  input wire logic [2:0] hop_hw_code,
  input wire logic ref_osc_clk_pin,
  output touch_osc_pkg::cap_code_t ref_cap_code,
  output logic [15:0] ref_cap_ff,
  output logic ref_osc_en,
  output logic key_osc_en,
  output logic key_freq_double_en,
  output logic module_filter_en,
  output logic hop_ctrl_select,
  output logic [2:0] hop_freq_code,
  output logic [10:0] hop_freq_khz,
  output logic slot_clk_select,
  output logic slot_tick,
  output logic [3:0] key_input_en,
  output logic [4*NUM_MODULES-1:0] touch_inputs
);
  import touch_osc_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic reg_sel_e decode(input logic [AW-1:0] a);
    case (a[3:0])
      `OFS_CAP_LOW: decode = SEL_CAP_LOW;
      `OFS_CAP_HIGH: decode = SEL_CAP_HIGH;
      `OFS_OSC_CFG: decode = SEL_OSC_CFG;
      `OFS_EN_CFG: decode = SEL_EN_CFG;
      default: decode = SEL_NONE;
    endcase
    // Upper address bits must be clear or the access is unmapped
    if ((a >> 4) != '0) decode = SEL_NONE;
  endfunction

  function automatic logic [10:0] hop_table(input logic [2:0] c);
    case (c)
      3'h0: hop_table = 11'h3FC;
      3'h1: hop_table = 11'h410;
      3'h2: hop_table = 11'h423;
      3'h3: hop_table = 11'h432;
      3'h4: hop_table = 11'h43D;
      3'h5: hop_table = 11'h44B;
      3'h6: hop_table = 11'h457;
      default: hop_table = 11'h465;
    endcase
  endfunction

  logic [5:0] osc_cfg;
  logic [2:0] hop_field;
  logic start_d;
  logic busy_d;
  logic start_rise;
  logic busy_fall;
  logic auto_mode;
  logic ref_set_ok;
  logic wr_go;
  reg_sel_e wr_sel;
  reg_sel_e rd_sel;
  logic wr_lane;
  logic ref_sync1;
  logic ref_sync2;
  logic ref_sync3;
  logic [1:0] div4;

  assign hop_field = osc_cfg[2:0];
  assign auto_mode = (scan_mode_select == SCAN_AUTO);  // see RQ19
  assign start_rise = scan_start && !start_d;  // see RQ20
  assign busy_fall = !scan_busy && busy_d;  // see RQ23
  // Module 0 always owns its oscillator; others only when self-timed
  assign ref_set_ok = (MODULE_IDX == 0) ||
    ((key_input_en != `KEYS_RST) && !slot_clk_select && !shared_slot_counter_sel);  // see RQ14
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign wr_sel = decode(s_axi_awaddr);
  assign wr_lane = wr_go && s_axi_wstrb[0];

  // ************************************************************
  // Bus write channel
  // ************************************************************
  // Address and data are taken together so no skid storage is needed
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Bus read channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
      rd_sel <= SEL_NONE;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      rd_sel <= decode(s_axi_araddr);
      s_axi_rresp <= (decode(s_axi_araddr) == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      case (decode(s_axi_araddr))
        SEL_CAP_LOW: s_axi_rdata <= {24'h000000, ref_cap_code[7:0]};
        SEL_CAP_HIGH: s_axi_rdata <= {30'h0, ref_cap_code[9:8]};  // see RQ1
        SEL_OSC_CFG: s_axi_rdata <= {26'h0, osc_cfg};  // see RQ4
        SEL_EN_CFG: s_axi_rdata <= {24'h000000, slot_clk_select, 1'b0,
          ref_osc_en, key_osc_en, key_input_en};  // see RQ4
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Capacitor code
  // ************************************************************
  // Hardware reload beats a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cap_code <= `CAP_RST;
    end else if (auto_mode && slot_end) begin
      ref_cap_code <= mem_cap_code;  // see RQ2
    end else if (wr_lane && wr_sel == SEL_CAP_LOW) begin
      ref_cap_code[7:0] <= s_axi_wdata[7:0];  // see RQ1
    end else if (wr_lane && wr_sel == SEL_CAP_HIGH) begin
      ref_cap_code[9:8] <= s_axi_wdata[1:0];  // see RQ1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cap_ff <= 16'h0000;
    end else begin
      // Product stays below 2^26, so the 32-bit product never overflows
      ref_cap_ff <= 16'((32'(ref_cap_code) * `CAP_FULL_FF) >> `CAP_SHIFT);  // see RQ3
    end
  end

  // ************************************************************
  // Oscillator configuration
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cfg <= `OSC_RST;
    end else if (wr_lane && wr_sel == SEL_OSC_CFG) begin
      osc_cfg <= s_axi_wdata[5:0];  // see RQ4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_freq_double_en <= 1'b0;
      module_filter_en <= 1'b0;
      hop_ctrl_select <= 1'b0;
      hop_freq_code <= 3'h0;
      hop_freq_khz <= 11'h000;
    end else begin
      key_freq_double_en <= osc_cfg[`OSC_DBL_BIT];  // see RQ5
      module_filter_en <= osc_cfg[`OSC_FIL_BIT];  // see RQ6
      hop_ctrl_select <= osc_cfg[`OSC_HOPC_BIT];
      // Field is ignored whenever the hardware hopper owns the frequency
      hop_freq_code <= osc_cfg[`OSC_HOPC_BIT] ? hop_hw_code : hop_field;  // see RQ7, see RQ9
      hop_freq_khz <= hop_table(osc_cfg[`OSC_HOPC_BIT] ? hop_hw_code : hop_field);  // see RQ8
    end
  end

  // ************************************************************
  // Scan edge detection and oscillator enables
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_d <= 1'b0;
      busy_d <= 1'b0;
    end else begin
      start_d <= scan_start;
      busy_d <= scan_busy;  // see RQ21
    end
  end

  // Start-rise set is tested first so it wins over busy fall and writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_osc_en <= 1'b0;
    end else if (auto_mode && start_rise && ref_set_ok) begin
      ref_osc_en <= 1'b1;  // see RQ13, see RQ14
    end else if (busy_fall) begin
      ref_osc_en <= 1'b0;  // see RQ12
    end else if (wr_lane && wr_sel == SEL_EN_CFG) begin
      ref_osc_en <= s_axi_wdata[`EN_ROEN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_osc_en <= 1'b0;
    end else if (auto_mode && start_rise) begin
      key_osc_en <= 1'b1;  // see RQ16
    end else if (busy_fall) begin
      key_osc_en <= 1'b0;  // see RQ16
    end else if (wr_lane && wr_sel == SEL_EN_CFG) begin
      key_osc_en <= s_axi_wdata[`EN_KOEN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_clk_select <= 1'b0;
      key_input_en <= `KEYS_RST;
    end else if (wr_lane && wr_sel == SEL_EN_CFG) begin
      slot_clk_select <= s_axi_wdata[`EN_TSS_BIT];
      key_input_en <= s_axi_wdata[3:0];  // see RQ17
    end
  end

  // ************************************************************
  // Global key map
  // ************************************************************
  generate
    for (genvar g = 0; g < 4 * NUM_MODULES; g++) begin : g_key
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          touch_inputs[g] <= 1'b0;
        end else if (g / `KEYS_PER_MOD == MODULE_IDX) begin
          touch_inputs[g] <= key_input_en[g % `KEYS_PER_MOD];  // see RQ18
        end else begin
          touch_inputs[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Slot counter clock source
  // ************************************************************
  // Reference oscillator is asynchronous, so its edges are only usable
  // when well below half of the system clock rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_sync1 <= 1'b0;
      ref_sync2 <= 1'b0;
      ref_sync3 <= 1'b0;
      div4 <= 2'h0;
    end else begin
      ref_sync1 <= ref_osc_clk_pin;
      ref_sync2 <= ref_sync1;
      ref_sync3 <= ref_sync2;
      div4 <= div4 + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_tick <= 1'b0;
    end else if (slot_clk_select) begin
      slot_tick <= (div4 == `DIV4_LAST);  // see RQ10
    end else begin
      slot_tick <= ref_osc_en && ref_sync2 && !ref_sync3;  // see RQ10, see RQ22
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cap_reload_a: assert property (  // see RQ2
    auto_mode && slot_end |=> ref_cap_code == $past(mem_cap_code))
    else $error("capacitor code not reloaded at slot end");
  cap_value_a: assert property (  // see RQ3
    ref_cap_ff == 16'((32'($past(ref_cap_code)) * `CAP_FULL_FF) >> `CAP_SHIFT))
    else $error("capacitance value mismatch");
  rsv_bits_a: assert property (  // see RQ4
    s_axi_rvalid && (rd_sel == SEL_OSC_CFG || rd_sel == SEL_EN_CFG)
      |-> s_axi_rdata[31:8] == 24'h000000 && !(rd_sel == SEL_OSC_CFG && |s_axi_rdata[7:6])
      && !(rd_sel == SEL_EN_CFG && s_axi_rdata[6]))
    else $error("reserved bits read nonzero");
  hop_src_a: assert property (  // see RQ7
    osc_cfg[`OSC_HOPC_BIT] |=> hop_freq_code == $past(hop_hw_code))
    else $error("hop code ignores hardware source");
  busy_clear_a: assert property (  // see RQ12
    busy_fall && !(auto_mode && start_rise) |=> !ref_osc_en && !key_osc_en)
    else $error("enables not cleared on busy fall");
  auto_set_a: assert property (  // see RQ13
    auto_mode && start_rise && ref_set_ok |=> ref_osc_en)
    else $error("reference enable not set on start");
  gate_hold_a: assert property (  // see RQ14
    auto_mode && start_rise && !ref_set_ok && !busy_fall
      && !(wr_lane && wr_sel == SEL_EN_CFG) |=> $stable(ref_osc_en))
    else $error("reference enable changed while gated");
  key_set_a: assert property (  // see RQ16
    auto_mode && start_rise |=> key_osc_en)
    else $error("key enable not set on start");
  key_map_a: assert property (  // see RQ18
    touch_inputs[`KEYS_PER_MOD*MODULE_IDX +: `KEYS_PER_MOD] == $past(key_input_en))
    else $error("global key map mismatch");
  tick_div_a: assert property (  // see RQ10
    (slot_clk_select && $stable(slot_clk_select)) [*4] |-> $countones({slot_tick,
      $past(slot_tick), $past(slot_tick, 2), $past(slot_tick, 3)}) == 1)
    else $error("divided slot tick not one in four");
  wr_resp_a: assert property (
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");

  auto_scan_c: cover property (auto_mode && start_rise ##[1:50] busy_fall);
  manual_scan_c: cover property (!auto_mode && ref_osc_en && start_rise);
  reload_c: cover property (auto_mode && slot_end);
  hop_hw_c: cover property (hop_ctrl_select && hop_freq_code == 3'h7);
endmodule

// File: dv/touch_pad_model.sv
// Reference oscillator of the touch pads as seen at the block's sense pin
module touch_pad_model (
  input wire logic ref_osc_en,
  output logic ref_osc_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Oscillator
  // ************************************************************
  // Period unrelated to aclk; the pin rests low while the oscillator is off
  initial begin
    ref_osc_clk_pin = 1'b0;
    forever begin
      #90;
      ref_osc_clk_pin = ref_osc_en ? ~ref_osc_clk_pin : 1'b0;
    end
  end
endmodule

// File: dv/test_touch_module_osc_control.sv
// Self-checking bench for the touch oscillator control block
`include "touch_osc_cfg.svh"
module test_touch_module_osc_control;
  timeunit 1ns;
  timeprecision 1ns;
  import touch_osc_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  localparam logic [4:0] a_low = 5'(`OFS_CAP_LOW);
  localparam logic [4:0] a_high = 5'(`OFS_CAP_HIGH);
  localparam logic [4:0] a_osc = 5'(`OFS_OSC_CFG);
  localparam logic [4:0] a_en = 5'(`OFS_EN_CFG);
  localparam logic [10:0] khz [8] = '{1020, 1040, 1059, 1074, 1085, 1099, 1111, 1125};
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, key_input_en;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic scan_start, scan_busy, shared_slot_counter_sel, slot_end, ref_osc_clk_pin;
  scan_mode_e scan_mode_select;
  cap_code_t mem_cap_code, ref_cap_code;
  logic [2:0] hop_hw_code, hop_freq_code;
  logic [15:0] ref_cap_ff;
  logic ref_osc_en, key_osc_en, key_freq_double_en, module_filter_en, hop_ctrl_select;
  logic [10:0] hop_freq_khz;
  logic slot_clk_select, slot_tick;
  logic [23:0] touch_inputs;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  touch_module_osc_control #(.MODULE_IDX(1), .NUM_MODULES(6), .AW(5)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scan_start, .scan_busy, .scan_mode_select,
    .shared_slot_counter_sel, .slot_end, .mem_cap_code, .hop_hw_code, .ref_osc_clk_pin,
    .ref_cap_code, .ref_cap_ff, .ref_osc_en, .key_osc_en, .key_freq_double_en,
    .module_filter_en, .hop_ctrl_select, .hop_freq_code, .hop_freq_khz, .slot_clk_select,
    .slot_tick, .key_input_en, .touch_inputs
  );
  touch_pad_model pads (.ref_osc_en(ref_osc_en), .ref_osc_clk_pin(ref_osc_clk_pin));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic results();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data go up together; the slave takes them only as a pair
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(resp));
    @(posedge aclk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h000000, exp});
    chk(32'(s_axi_rresp), 32'(resp));
    @(posedge aclk);
  endtask
  task automatic scan(input logic level);
    scan_start <= level;
    scan_busy <= level;
    repeat (2) @(posedge aclk);
  endtask
  task automatic ticks(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge aclk);
      if (slot_tick === 1'b1) c++;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    rd(a_high, 8'h00, `RESP_OKAY);
    rd(5'h10, 8'h00, `RESP_SLVERR);
    wr(5'h10, 8'hFF, `RESP_SLVERR);
    wr(a_low, 8'hA5, `RESP_OKAY);
    wr(a_high, 8'hFF, `RESP_OKAY);
    rd(a_high, 8'h03, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(ref_cap_code), 32'h3A5);
    chk(32'(ref_cap_ff), (32'h3A5 * 32'h0000C350) >> 10);
    wr(a_osc, 8'hFF, `RESP_OKAY);
    rd(a_osc, 8'h3F, `RESP_OKAY);
    chk({key_freq_double_en, module_filter_en, hop_ctrl_select}, 3'h7);
    wr(a_osc, 8'h00, `RESP_OKAY);
    chk({key_freq_double_en, module_filter_en, hop_ctrl_select}, 3'h0);
    wr(a_en, 8'hCF, `RESP_OKAY);
    rd(a_en, 8'h8F, `RESP_OKAY);
    chk({slot_clk_select, key_input_en}, 5'h1F);
    chk(touch_inputs, 24'h0000F0);
    wr(a_en, 8'h04, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(touch_inputs, 24'h000040);
  endtask
  task automatic t_hop();
    for (int i = 0; i < 8; i++) begin
      wr(a_osc, 8'(i), `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'(hop_freq_code), 32'(i));
      chk(32'(hop_freq_khz), 32'(khz[i]));
    end
    hop_hw_code <= 3'h5;
    wr(a_osc, 8'h0A, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(hop_freq_code), 32'h5);
  endtask
  task automatic t_auto();
    // Module 1 may only start its reference oscillator when keys, slot clock, sharing allow
    wr(a_en, 8'h01, `RESP_OKAY);
    scan(1'b1);
    chk({ref_osc_en, key_osc_en}, 2'h3);
    scan(1'b0);
    chk({ref_osc_en, key_osc_en}, 2'h0);
    shared_slot_counter_sel <= 1'b1;
    scan(1'b1);
    chk({ref_osc_en, key_osc_en}, 2'h1);
    scan(1'b0);
    shared_slot_counter_sel <= 1'b0;
    wr(a_en, 8'hA1, `RESP_OKAY);
    scan(1'b1);
    chk(32'(ref_osc_en), 32'h1);
    scan(1'b0);
    wr(a_en, 8'h00, `RESP_OKAY);
    scan(1'b1);
    chk(32'(ref_osc_en), 32'h0);
    scan(1'b0);
    mem_cap_code <= 10'h2C7;
    slot_end <= 1'b1;
    @(posedge aclk);
    slot_end <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(ref_cap_code), 32'h2C7);
    rd(a_low, 8'hC7, `RESP_OKAY);
  endtask
  task automatic t_manual();
    int c;
    scan_mode_select <= SCAN_MANUAL;
    wr(a_en, 8'h31, `RESP_OKAY);
    scan(1'b1);
    chk({ref_osc_en, key_osc_en}, 2'h3);
    ticks(40, c);
    chk(32'(c > 3), 32'h1);
    scan(1'b0);
    chk({ref_osc_en, key_osc_en}, 2'h0);
    ticks(20, c);
    chk(32'(c), 32'h0);
    wr(a_en, 8'h80, `RESP_OKAY);
    ticks(16, c);
    chk(32'(c), 32'h4);
  endtask

  // ************************************************************
  // Clock, timeout and main sequence
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Whole run takes well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h1;
    {scan_start, scan_busy, shared_slot_counter_sel, slot_end} = 4'h0;
    scan_mode_select = SCAN_AUTO;
    mem_cap_code = 10'h000;
    hop_hw_code = 3'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_hop();
    t_auto();
    t_manual();
    results();
  end
endmodule
